// >>> design/rso_report.v
// report-supported-operation-codes command handler with apb registers
// assumes software loads the 12-byte cdb, writes start, and a transport
// drains the parameter bytes from the byte stream with valid/ready
`timescale 1ns/1ps
`include "rso_defs.vh"

// Functional notes
// - accept only opcode A3h, action 0Ch
// - timeouts bit set appends timeout descriptors
// - timeouts bit clear omits timeout descriptors
// - option 000b returns full command list
// - option 001b single record, action ignored
// - 001b on action opcode gives check
// - 010b opcode-action record; plain opcode checks
// - 011b supported cases report code 011b
// - 011b otherwise report not supported 001b
// - requested opcode byte3, action bytes 4-5
// - transfer truncated to allocation length bytes 6-9
// - length field holds true length after the 4-byte header
// - list: length header then 8-byte descriptors
// - support code values per defined encoding
module rso_report #(
    parameter NUM_CMDS = 6,
    parameter [31:0] TMO_NOMINAL = 32'h0000_001E,
    parameter [31:0] TMO_RECOMMEND = 32'h0000_003C
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    output reg [7:0] dout_byte,
    output reg dout_valid,
    output reg dout_last,
    input wire dout_ready
);

    // ****************************************
    // supported command table
    // ****************************************
    // entry: {opcode, service action, action valid, cdb length}
    function [32:0] tbl;
        input integer i;
        begin
            case (i)
                0: tbl = {8'h00, 16'h0000, 1'b0, 8'd6};
                1: tbl = {8'h12, 16'h0000, 1'b0, 8'd6};
                2: tbl = {8'h28, 16'h0000, 1'b0, 8'd10};
                3: tbl = {8'h2A, 16'h0000, 1'b0, 8'd10};
                4: tbl = {8'hA0, 16'h0000, 1'b0, 8'd12};
                default: tbl = {8'hA3, 16'h000C, 1'b1, 8'd12};
            endcase
        end
    endfunction

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    // ****************************************
    // registers
    // ****************************************
    reg [31:0] cdb0, cdb1, cdb2; // cdb bytes 0..3, 4..7, 8..11; byte 0 in low lane
    reg [1:0] irq_stat; // sticky done / check
    reg [1:0] irq_mask; // enables for irq
    reg state; // idle or streaming
    reg check; // last command ended in check condition
    reg [31:0] total; // true parameter data length
    reg [31:0] limit; // bytes actually sent
    reg [31:0] pos; // bytes loaded so far
    reg [7:0] off; // byte offset within current descriptor
    reg [7:0] idx; // current descriptor index
    reg all_fmt; // list format selected
    reg tmo_on; // timeout descriptors appended
    reg [2:0] support; // support code of single record
    reg [32:0] sel; // table entry of single record
    reg done_evt; // one-cycle event: stream finished
    reg check_evt; // one-cycle event: check raised

    // ****************************************
    // cdb fields
    // ****************************************
    wire [7:0] f_op = cdb0[7:0];
    wire [7:0] f_b1 = cdb0[15:8];
    wire [7:0] f_b2 = cdb0[23:16];
    wire tmo_req = f_b2[7]; // timeouts_request_bit
    wire [2:0] f_ro = f_b2[2:0];
    wire [7:0] f_req_op = cdb0[31:24];
    wire [15:0] f_req_sa = {cdb1[7:0], cdb1[15:8]};
    wire [31:0] f_alloc = {cdb1[23:16], cdb1[31:24], cdb2[7:0], cdb2[15:8]};

    // ****************************************
    // apb access decode
    // ****************************************
    // answer comes in the second access cycle, so reads have a flop stage
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire known = (paddr == `RSO_REG_CDB0) | (paddr == `RSO_REG_CDB1) | (paddr == `RSO_REG_CDB2) |
                 (paddr == `RSO_REG_CTRL) | (paddr == `RSO_REG_STATUS) | (paddr == `RSO_REG_IRQ_STAT) |
                 (paddr == `RSO_REG_IRQ_MASK) | (paddr == `RSO_REG_TOTAL) | (paddr == `RSO_REG_XFER);
    wire start = wr & (paddr == `RSO_REG_CTRL) & pwdata[`RSO_CTRL_START] & (state == ST_IDLE);

    // ****************************************
    // per-entry match against request
    // ****************************************
    wire [NUM_CMDS-1:0] m_plain; // opcode matches, no service actions
    wire [NUM_CMDS-1:0] m_saop; // opcode matches, has service actions
    wire [NUM_CMDS-1:0] m_pair; // opcode and service action match
    genvar g;
    generate
        for (g = 0; g < NUM_CMDS; g = g + 1) begin : g_match
            wire [32:0] e = tbl(g);
            assign m_plain[g] = (e[32:25] == f_req_op) & ~e[8];
            assign m_saop[g] = (e[32:25] == f_req_op) & e[8];
            assign m_pair[g] = m_saop[g] & (e[24:9] == f_req_sa);
        end
    endgenerate

    // ****************************************
    // command decode at start
    // ****************************************
    reg bad; // invalid field found
    reg [2:0] sup_n; // support code to report
    reg [32:0] sel_n; // selected entry
    reg [31:0] tot_n; // full length
    integer k;
    always @* begin
        bad = 1'b0;
        sup_n = `RSO_SUP_NO;
        sel_n = 33'd0;
        tot_n = 32'd0;
        for (k = 0; k < NUM_CMDS; k = k + 1) begin
            if (m_plain[k] | m_pair[k]) sel_n = tbl(k);
        end
        // reserved bits must be zero, and the command must be this one
        if (f_op != `RSO_OPCODE || f_b1 != {3'b000, `RSO_SVC_ACTION} || f_b2[6:3] != 4'h0) bad = 1'b1;
        case (f_ro)
            `RSO_RO_ALL: begin
                // requested opcode and action ignored
                tot_n = `RSO_HDR_LEN + NUM_CMDS * {24'd0, `RSO_DESC_LEN + (tmo_req ? `RSO_TMO_LEN : 8'd0)};
            end
            `RSO_RO_OP: begin
                if (|m_saop) bad = 1'b1;
                if (|m_plain) sup_n = `RSO_SUP_STD;
            end
            `RSO_RO_OPSA: begin
                if (|m_plain || !(|m_saop)) bad = 1'b1;
                if (|m_pair) sup_n = `RSO_SUP_STD;
            end
            `RSO_RO_CHECK: begin
                // plain opcode needs action 00h; action opcode needs a listed action
                if ((|m_plain && f_req_sa == 16'h0000) || |m_pair) sup_n = `RSO_SUP_STD;
                else sup_n = `RSO_SUP_NO;
            end
            default: bad = 1'b1;
        endcase
        if (f_ro != `RSO_RO_ALL) begin
            // unsupported record stops after the cdb size field
            if (sup_n == `RSO_SUP_STD) begin
                tot_n = `RSO_HDR_LEN + {24'd0, sel_n[7:0]} + (tmo_req ? {24'd0, `RSO_TMO_LEN} : 32'd0);
            end else begin
                tot_n = `RSO_HDR_LEN;
            end
        end
    end

    // ****************************************
    // timeout descriptor byte
    // ****************************************
    function [7:0] tmo_byte;
        input [7:0] t;
        begin
            case (t)
                8'd1: tmo_byte = `RSO_TMO_ADD_LEN;
                8'd4: tmo_byte = TMO_NOMINAL[31:24];
                8'd5: tmo_byte = TMO_NOMINAL[23:16];
                8'd6: tmo_byte = TMO_NOMINAL[15:8];
                8'd7: tmo_byte = TMO_NOMINAL[7:0];
                8'd8: tmo_byte = TMO_RECOMMEND[31:24];
                8'd9: tmo_byte = TMO_RECOMMEND[23:16];
                8'd10: tmo_byte = TMO_RECOMMEND[15:8];
                8'd11: tmo_byte = TMO_RECOMMEND[7:0];
                default: tmo_byte = 8'h00;
            endcase
        end
    endfunction

    // ****************************************
    // next parameter byte
    // ****************************************
    reg [7:0] next_byte;
    reg [32:0] ent; // descriptor entry being sent
    reg [7:0] u; // offset into usage data
    reg [31:0] hdr_len; // length field contents
    always @* begin
        ent = tbl(idx);
        u = pos[7:0] - 8'd4;
        hdr_len = total - `RSO_HDR_LEN;
        next_byte = 8'h00;
        if (all_fmt) begin
            if (pos < `RSO_HDR_LEN) begin
                // big-endian length of the data after the header
                case (pos[1:0])
                    2'd0: next_byte = hdr_len[31:24];
                    2'd1: next_byte = hdr_len[23:16];
                    2'd2: next_byte = hdr_len[15:8];
                    default: next_byte = hdr_len[7:0];
                endcase
            end else begin
                case (off)
                    8'd0: next_byte = ent[32:25];
                    8'd2: next_byte = ent[24:17];
                    8'd3: next_byte = ent[16:9];
                    8'd5: next_byte = {6'd0, tmo_on, ent[8]};
                    8'd7: next_byte = ent[7:0];
                    default: next_byte = (off >= `RSO_DESC_LEN) ? tmo_byte(off - `RSO_DESC_LEN) : 8'h00;
                endcase
            end
        end else begin
            case (pos[7:0])
                8'd0: next_byte = 8'h00;
                8'd1: next_byte = {tmo_on, 4'h0, support};
                8'd2: next_byte = 8'h00;
                8'd3: next_byte = (support == `RSO_SUP_STD) ? sel[7:0] : 8'h00;
                default: begin
                    if (u == 8'd0) next_byte = sel[32:25];
                    else if (u == 8'd1 && sel[8]) next_byte = sel[16:9];
                    else if (u < sel[7:0]) next_byte = 8'hFF; // every cdb bit usable
                    else next_byte = tmo_byte(u - sel[7:0]);
                end
            endcase
        end
    end

    // ****************************************
    // command sequencer and byte stream
    // ****************************************
    // output register reloads only when empty or taken, so the transport can stall
    wire take = ~dout_valid | dout_ready;
    wire [7:0] desc_len = `RSO_DESC_LEN + (tmo_on ? `RSO_TMO_LEN : 8'd0);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            check <= 1'b0;
            total <= 32'd0;
            limit <= 32'd0;
            pos <= 32'd0;
            off <= 8'd0;
            idx <= 8'd0;
            all_fmt <= 1'b0;
            tmo_on <= 1'b0;
            support <= `RSO_SUP_NA;
            sel <= 33'd0;
            dout_byte <= 8'h00;
            dout_valid <= 1'b0;
            dout_last <= 1'b0;
            done_evt <= 1'b0;
            check_evt <= 1'b0;
        end else begin
            done_evt <= 1'b0;
            check_evt <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        check <= bad;
                        pos <= 32'd0;
                        off <= 8'd0;
                        idx <= 8'd0;
                        if (bad) begin
                            // no data phase on a check condition
                            check_evt <= 1'b1;
                            total <= 32'd0;
                            limit <= 32'd0;
                        end else begin
                            all_fmt <= (f_ro == `RSO_RO_ALL);
                            tmo_on <= tmo_req;
                            support <= sup_n;
                            sel <= sel_n;
                            total <= tot_n;
                            limit <= (tot_n < f_alloc) ? tot_n : f_alloc;
                            state <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (take) begin
                        if (pos < limit) begin
                            dout_byte <= next_byte;
                            dout_valid <= 1'b1;
                            dout_last <= (pos + 32'd1 == limit);
                            pos <= pos + 32'd1;
                            if (all_fmt && pos >= `RSO_HDR_LEN) begin
                                // step through the descriptors
                                if (off + 8'd1 == desc_len) begin
                                    off <= 8'd0;
                                    idx <= idx + 8'd1;
                                end else begin
                                    off <= off + 8'd1;
                                end
                            end
                        end else begin
                            dout_valid <= 1'b0;
                            dout_last <= 1'b0;
                            done_evt <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // apb slave and interrupt registers
    // ****************************************
    // status set wins over a write-one clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdb0 <= 32'h0000_0000;
            cdb1 <= 32'h0000_0000;
            cdb2 <= 32'h0000_0000;
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
            irq <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~known;
            // an unmapped write also zeroes the read bus, so an error never carries stale data
            if (psel & penable & ~pready & (~pwrite | ~known)) begin
                case (paddr)
                    `RSO_REG_CDB0: prdata <= cdb0;
                    `RSO_REG_CDB1: prdata <= cdb1;
                    `RSO_REG_CDB2: prdata <= cdb2;
                    `RSO_REG_STATUS: prdata <= {8'd0, `RSO_ASCQ_INV_FIELD & {8{check}},
                        `RSO_ASC_INV_FIELD & {8{check}}, `RSO_SK_ILLEGAL & {4{check}}, 2'd0, check, state};
                    `RSO_REG_IRQ_STAT: prdata <= {30'd0, irq_stat};
                    `RSO_REG_IRQ_MASK: prdata <= {30'd0, irq_mask};
                    `RSO_REG_TOTAL: prdata <= total;
                    `RSO_REG_XFER: prdata <= limit;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            // cdb is frozen while a command is in flight
            if (wr && state == ST_IDLE) begin
                if (paddr == `RSO_REG_CDB0) cdb0 <= pwdata;
                if (paddr == `RSO_REG_CDB1) cdb1 <= pwdata;
                if (paddr == `RSO_REG_CDB2) cdb2 <= pwdata;
            end
            if (wr && paddr == `RSO_REG_IRQ_MASK) irq_mask <= pwdata[`RSO_IRQ_W-1:0];
            irq_stat <= (irq_stat & ~((wr && paddr == `RSO_REG_IRQ_STAT) ? pwdata[`RSO_IRQ_W-1:0] : 2'b00))
                        | {check_evt, done_evt};
            irq <= |(irq_stat & irq_mask);
        end
    end

endmodule

// >>> design/rso_defs.vh
// constants for the supported-operation-code report block
// assumes an apb master with 32-bit data and byte addresses
`ifndef RSO_DEFS_VH
`define RSO_DEFS_VH

// ****************************************
// command identity
// ****************************************
`define RSO_OPCODE 8'hA3
`define RSO_SVC_ACTION 5'h0C

// ****************************************
// reporting options
// ****************************************
`define RSO_RO_ALL 3'b000
`define RSO_RO_OP 3'b001
`define RSO_RO_OPSA 3'b010
`define RSO_RO_CHECK 3'b011

// ****************************************
// support codes
// ****************************************
`define RSO_SUP_NA 3'b000
`define RSO_SUP_NO 3'b001
`define RSO_SUP_STD 3'b011
`define RSO_SUP_VEND 3'b101

// ****************************************
// sense data for an invalid field
// ****************************************
`define RSO_SK_ILLEGAL 4'h5
`define RSO_ASC_INV_FIELD 8'h24
`define RSO_ASCQ_INV_FIELD 8'h00

// ****************************************
// layout sizes in bytes
// ****************************************
`define RSO_HDR_LEN 32'h0000_0004
`define RSO_DESC_LEN 8'h08
`define RSO_TMO_LEN 8'h0C
`define RSO_TMO_ADD_LEN 8'h0A

// ****************************************
// register byte addresses
// ****************************************
`define RSO_REG_CDB0 8'h00
`define RSO_REG_CDB1 8'h04
`define RSO_REG_CDB2 8'h08
`define RSO_REG_CTRL 8'h0C
`define RSO_REG_STATUS 8'h10
`define RSO_REG_IRQ_STAT 8'h14
`define RSO_REG_IRQ_MASK 8'h18
`define RSO_REG_TOTAL 8'h1C
`define RSO_REG_XFER 8'h20

// ****************************************
// field positions
// ****************************************
`define RSO_CTRL_START 0
`define RSO_IRQ_DONE 0
`define RSO_IRQ_CHECK 1
`define RSO_IRQ_W 2

`endif

// >>> tb/rso_report_props.sv
// port checker for the report block, bound to the design top
// assumes the apb master holds each request until pready is high
`timescale 1ns/1ps
`include "rso_defs.vh"
module rso_report_props (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic irq,
    input logic [7:0] dout_byte,
    input logic dout_valid,
    input logic dout_last,
    input logic dout_ready
);
    // ****************************************
    // allocation mirror
    // ****************************************
    logic [15:0] al_hi; // allocation bytes 6-7
    logic [15:0] al_lo; // allocation bytes 8-9
    logic [31:0] sent; // bytes taken since start
    wire wr_ok = psel && penable && pready && pwrite; // completed write
    // busy-time cdb writes are not mirrored apart; the bench never issues them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            al_hi <= 16'h0000;
            al_lo <= 16'h0000;
            sent <= 32'h0000_0000;
        end else begin
            if (wr_ok && paddr == `RSO_REG_CDB1) al_hi <= {pwdata[23:16], pwdata[31:24]};
            if (wr_ok && paddr == `RSO_REG_CDB2) al_lo <= {pwdata[7:0], pwdata[15:8]};
            if (wr_ok && paddr == `RSO_REG_CTRL && pwdata[0]) sent <= 32'h0000_0000;
            else if (dout_valid && dout_ready) sent <= sent + 32'h0000_0001;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_one_wait;
        !pready ##1 pready;
    endsequence
    a_access_wait: assert property (s_setup_access |-> s_one_wait)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("slave error without ready or with data");
    a_byte_holds: assert property (dout_valid && !dout_ready |=> dout_valid && $stable(dout_byte) && $stable(dout_last))
        else $error("stream byte dropped while stalled");
    a_last_in_frame: assert property (dout_last |-> dout_valid)
        else $error("last marker without valid");
    a_frame_ends: assert property (dout_valid && dout_ready && dout_last |=> !dout_valid [*3])
        else $error("stream continues after last byte");
    a_within_alloc: assert property (dout_valid |-> sent < {al_hi, al_lo})
        else $error("byte offered beyond allocation");
endmodule
bind rso_report rso_report_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .dout_byte(dout_byte), .dout_valid(dout_valid), .dout_last(dout_last), .dout_ready(dout_ready));

// >>> tb/rso_sink.sv
// stream sink standing for the initiator that drains parameter data
// assumes one clock and the active-low asynchronous reset of the block
`timescale 1ns/1ps
module rso_sink (
    input logic pclk,
    input logic presetn,
    input logic slow,
    input logic [7:0] dout_byte,
    input logic dout_valid,
    input logic dout_last,
    output logic dout_ready
);
    // ****************************************
    // capture
    // ****************************************
    logic [7:0] got[$]; // bytes taken, in order
    logic [31:0] lastn; // count when the last marker was taken
    logic [1:0] ph; // stall phase
    // slow mode drops ready one cycle in four, so holds get exercised
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 2'b00;
            dout_ready <= 1'b0;
            lastn <= 32'h0000_0000;
        end else begin
            ph <= ph + 2'b01;
            dout_ready <= !slow || ph != 2'b00;
            if (dout_valid && dout_ready) begin
                got.push_back(dout_byte);
                if (dout_last) lastn <= 32'(got.size());
            end
        end
    end
endmodule

// >>> tb/supported_opcode_report_tb.sv
// self-checking bench for the report block
// assumes the sink model and the bound checker are compiled first
`timescale 1ns/1ps
`include "rso_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; $display("Error %s expected %h seen %h", n, e, g); end end
module supported_opcode_report_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready, pslverr, irq, dout_valid, dout_last, dout_ready;
    wire [7:0] dout_byte;
    logic [31:0] rd, ist, st, xf; // last read, irq status, status, sent count
    logic er; // last slave error
    int err_total = 0, checked = 0;
    always #5 pclk = ~pclk;
    rso_report i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .dout_byte(dout_byte), .dout_valid(dout_valid), .dout_last(dout_last), .dout_ready(dout_ready));
    rso_sink i_sink (.pclk(pclk), .presetn(presetn), .slow(slow), .dout_byte(dout_byte),
        .dout_valid(dout_valid), .dout_last(dout_last), .dout_ready(dout_ready));
    // ****************************************
    // bus and helpers
    // ****************************************
    // one apb transfer; an idle edge first keeps psel from toggling in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n == 20) err_total++;
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    function logic [7:0] g(input int i);
        g = i_sink.got[i];
    endfunction
    function logic [63:0] g8(input int i);
        g8 = {g(i), g(i + 1), g(i + 2), g(i + 3), g(i + 4), g(i + 5), g(i + 6), g(i + 7)};
    endfunction
    // load the cdb, start, and poll until done or check
    task go(input logic [7:0] op, b1, b2, rop, input logic [15:0] rsa, input logic [31:0] al);
        int n;
        i_sink.got.delete();
        apb(1'b1, `RSO_REG_CDB0, {rop, b2, b1, op});
        apb(1'b1, `RSO_REG_CDB1, {al[23:16], al[31:24], rsa[7:0], rsa[15:8]});
        apb(1'b1, `RSO_REG_CDB2, {16'h0000, al[7:0], al[15:8]});
        apb(1'b1, `RSO_REG_IRQ_STAT, 32'h0000_0003);
        apb(1'b1, `RSO_REG_CTRL, 32'h0000_0001);
        n = 0;
        ist = 32'h0000_0000;
        while (ist[1:0] == 2'b00 && n < 300) begin apb(1'b0, `RSO_REG_IRQ_STAT, 32'h0000_0000); ist = rd; n++; end
        if (ist[1:0] == 2'b00) err_total++;
        apb(1'b0, `RSO_REG_STATUS, 32'h0000_0000);
        st = rd;
        apb(1'b0, `RSO_REG_XFER, 32'h0000_0000);
        xf = rd;
        if (i_sink.got.size() > 0) `CHK("last pos", 32'(i_sink.got.size()), i_sink.lastn)
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, er)
        apb(1'b1, `RSO_REG_IRQ_MASK, 32'h0000_0000);
        go(`RSO_OPCODE, 8'h0C, 8'h00, 8'h00, 16'h0000, 32'h0000_0004);
        `CHK("masked irq", 1'b0, irq)
        apb(1'b1, `RSO_REG_IRQ_MASK, 32'h0000_0001);
        apb(1'b0, `RSO_REG_IRQ_MASK, 32'h0000_0000);
        `CHK("irq up", 1'b1, irq)
        apb(1'b1, `RSO_REG_IRQ_STAT, 32'h0000_0001);
        apb(1'b0, `RSO_REG_STATUS, 32'h0000_0000);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b1, `RSO_REG_IRQ_MASK, 32'h0000_0000);
        $display("test regs done");
    endtask
    // full list under stalls, then truncated with timeouts, then empty
    task t_all;
        slow <= 1'b1;
        go(`RSO_OPCODE, 8'h0C, 8'h00, 8'h55, 16'h1234, 32'h0000_03E8);
        `CHK("all size", 32'h0000_0034, 32'(i_sink.got.size()))
        `CHK("all hdr", 32'h0000_0030, {g(0), g(1), g(2), g(3)})
        `CHK("desc first", 64'h0000_0000_0000_0006, g8(4))
        `CHK("desc last", 64'hA300_000C_0001_000C, g8(44))
        go(`RSO_OPCODE, 8'h0C, 8'h80, 8'h00, 16'h0000, 32'h0000_000A);
        `CHK("trunc size", 32'h0000_000A, xf)
        `CHK("trunc hdr", 32'h0000_0078, {g(0), g(1), g(2), g(3)})
        `CHK("desc tmo flag", 8'h02, g(9))
        go(`RSO_OPCODE, 8'h0C, 8'h00, 8'h00, 16'h0000, 32'h0000_0000);
        `CHK("empty done", 2'b01, ist[1:0])
        slow <= 1'b0;
        $display("test all done");
    endtask
    task t_one;
        go(`RSO_OPCODE, 8'h0C, 8'h01, 8'h28, 16'hBEEF, 32'h0000_03E8);
        `CHK("one size", 32'h0000_000E, 32'(i_sink.got.size()))
        `CHK("one rec", 64'h0003_000A_28FF_FFFF, g8(0))
        go(`RSO_OPCODE, 8'h0C, 8'h81, 8'h28, 16'h0000, 32'h0000_03E8);
        `CHK("one tmo size", 32'h0000_001A, 32'(i_sink.got.size()))
        `CHK("one tmo desc", 64'h000A_0000_0000_001E, g8(14))
        go(`RSO_OPCODE, 8'h0C, 8'h02, 8'hA3, 16'h000C, 32'h0000_03E8);
        `CHK("pair rec", 64'h0003_000C_A30C_FFFF, g8(0))
        $display("test one done");
    endtask
    task automatic t_ro3;
        logic [7:0] op [6] = '{8'h28, 8'h28, 8'hA3, 8'hA3, 8'h55, 8'h28};
        logic [15:0] sa [6] = '{16'h0000, 16'h0005, 16'h000C, 16'h0005, 16'h0000, 16'h0005};
        logic [7:0] ex [6] = '{8'h03, 8'h01, 8'h03, 8'h01, 8'h01, 8'h81};
        logic [7:0] sz [6] = '{8'h0E, 8'h04, 8'h10, 8'h04, 8'h04, 8'h04};
        for (int k = 0; k < 6; k++) begin
            go(`RSO_OPCODE, 8'h0C, {k == 5, 4'h0, `RSO_RO_CHECK}, op[k], sa[k], 32'h0000_03E8);
            `CHK("support code", ex[k], g(1))
            `CHK("support size", sz[k], 32'(i_sink.got.size()))
        end
        $display("test option three done");
    endtask
    task automatic t_check;
        logic [7:0] b2 [7] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h00, 8'h00, 8'h02};
        logic [7:0] rq [7] = '{8'hA3, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55};
        for (int k = 0; k < 7; k++) begin
            go(k == 4 ? 8'hA2 : 8'hA3, k == 5 ? 8'h2C : 8'h0C, b2[k], rq[k], 16'h0000, 32'h0000_03E8);
            `CHK("check event", 2'b10, ist[1:0])
            `CHK("check sense", {`RSO_ASCQ_INV_FIELD, `RSO_ASC_INV_FIELD, `RSO_SK_ILLEGAL}, st[23:4])
            `CHK("check no data", 32'h0000_0000, 32'(i_sink.got.size()))
        end
        $display("test check done");
    endtask
    // ****************************************
    // run control
    // ****************************************
    task end_sim;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_all;
        t_one;
        t_ro3;
        t_check;
        end_sim;
    end
    // about 900 cycles expected; a hang past 50000 ends the run
    initial begin
        #500000;
        err_total++;
        end_sim;
    end
endmodule
